// *** pkg/tpt_pkg.sv ***
// Functional notes
// RULE_01 - Channel compare zero gives constant inactive output
// RULE_02 - Period match clears counter, raises both interrupts; code raises the period one, channel ones only at compare zero
// RULE_03 - Compare equal period plus one gives full duty
// RULE_04 - Trigger after channel match restarts, output asserted
// RULE_05 - Trigger before channel match suppresses its interrupt
// RULE_06 - Trigger after period match clears, keeps counting
// RULE_07 - Trigger before period match suppresses period interrupt
// RULE_08 - Triggered PWM channel interrupt on equal count
// RULE_09 - One-shot mode code 011, unit zero only
// RULE_10 - Enable waits; software trigger starts one-shot pulse
// RULE_11 - Channel 0 active while counting, else inactive
// RULE_12 - First trigger moves counter from max to zero
// RULE_13 - Pulse end clears counter, stops, awaits trigger
// RULE_14 - Triggers during a one-shot pulse are ignored
// RULE_15 - Delay equals compare; width period minus compare plus one
// RULE_16 - One-shot period and channel interrupt timing
// RULE_17 - Only the software trigger bit triggers
// RULE_18 - Channel compare above period gives no pulse
// RULE_19 - Per-channel output enable and waiting level bits
// RULE_20 - Two-bit field selects valid event edge
// RULE_21 - Counter readback returns current counter value
// RULE_22 - Input control and option registers have no effect
// RULE_23 - Buffers reload at counter clear after channel 1 write
// RULE_24 - PWM cycle period plus one, width compare value
// RULE_25 - Software trigger bit is a one-cycle pulse
package tpt_pkg;

    // ==========================================================
    // Register map (index on the address port)
    localparam logic [3:0] ADDR_CTL0 = 4'h0;
    localparam logic [3:0] ADDR_CTL1 = 4'h1;
    localparam logic [3:0] ADDR_OUTC = 4'h2;
    localparam logic [3:0] ADDR_INC  = 4'h3;
    localparam logic [3:0] ADDR_EDGE = 4'h4;
    localparam logic [3:0] ADDR_OPT  = 4'h5;
    localparam logic [3:0] ADDR_CNT  = 4'h6;
    localparam logic [3:0] ADDR_PER  = 4'h8;
    localparam logic [3:0] ADDR_CMP1 = 4'h9;
    localparam logic [3:0] ADDR_CMP2 = 4'hA;
    localparam logic [3:0] ADDR_CMP3 = 4'hB;

    // ==========================================================
    // Field positions and codes
    localparam int         CE_BIT    = 7;
    localparam int         TRIG_BIT  = 6;
    localparam int         EVSEL_BIT = 5;
    localparam int         EDGE_LSB  = 2;
    localparam logic [2:0] MODE_TRIG = 3'h2;
    localparam logic [2:0] MODE_ONES = 3'h3;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ==========================================================
    // Reset values and counter constants
    localparam logic [7:0]  RST_REG8 = 8'h00;
    localparam logic [15:0] RST_CCR  = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE  = 16'h0001;

    // Register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tpt_bus_req_s;

endpackage : tpt_pkg

// *** hdl/tpt_timer.sv ***
`timescale 1ns/10ps
module tpt_timer #(
    parameter bit UNIT_ZERO = 1'b1
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire logic                  count_tick,
    input  wire logic                  event_in,
    input  wire tpt_pkg::tpt_bus_req_s bus_req,
    output logic [15:0]                rdata,
    output logic                       period_match_irq,
    output logic [2:0]                 channel_match_irq,
    output logic                       period_output_pin,
    output logic [2:0]                 channel_output_pin
);
    import tpt_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0]  control_reg_zero;
    logic [7:0]  control_reg_one;
    logic [7:0]  output_control_reg;
    logic [7:0]  input_control_reg;
    logic [7:0]  edge_select_reg;
    logic [7:0]  option_reg;
    logic [15:0] ccr     [4];
    logic [15:0] buf_q   [4];
    logic        reload_pending;
    logic [15:0] cnt;
    logic        run;
    logic [2:0]  ev_sync;
    logic [3:0]  act;

    logic        wr_hit;
    logic        sw_trig;
    logic        mode_trig;
    logic        mode_ones;
    logic        active_mode;
    logic        ev_edge;
    logic        tick;
    logic        take_trig;
    logic        period_hit;
    logic        clear_evt;
    logic [15:0] next_cnt;
    logic        next_run;
    logic [3:0]  next_act;
    logic [2:0]  next_ch_irq;

    // Channel active decode for both pulse modes
    function automatic logic chan_active(input logic ones, input logic [15:0] c,
                                         input logic [15:0] b, input logic [15:0] p);
        if (ones)
            chan_active = (b <= p) && (c >= b); // RULE_15 RULE_18
        else
            chan_active = (c < b); // RULE_01 RULE_03 RULE_24
    endfunction : chan_active

    // ==========================================================
    // Register writes
    assign wr_hit = bus_req.wr;

    // Control and option registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_reg_zero   <= RST_REG8;
            control_reg_one    <= RST_REG8;
            output_control_reg <= RST_REG8;
            input_control_reg  <= RST_REG8;
            edge_select_reg    <= RST_REG8;
            option_reg         <= RST_REG8;
        end
        else if (clk_en && wr_hit)
        begin
            case (bus_req.addr)
                ADDR_CTL0: control_reg_zero   <= bus_req.wdata[7:0];
                ADDR_CTL1: control_reg_one    <= bus_req.wdata[7:0] & ~(8'h01 << TRIG_BIT); // RULE_25
                ADDR_OUTC: output_control_reg <= bus_req.wdata[7:0];
                ADDR_INC:  input_control_reg  <= bus_req.wdata[7:0]; // RULE_22
                ADDR_EDGE: edge_select_reg    <= bus_req.wdata[7:0];
                ADDR_OPT:  option_reg         <= bus_req.wdata[7:0]; // RULE_22
                default:   control_reg_zero   <= control_reg_zero;
            endcase
        end
    end

    // Compare registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
                ccr[i] <= RST_CCR;
        end
        else if (clk_en && wr_hit && bus_req.addr[3:2] == ADDR_PER[3:2])
        begin
            ccr[bus_req.addr[1:0]] <= bus_req.wdata;
        end
    end

    // ==========================================================
    // Mode and trigger decode
    assign sw_trig     = wr_hit && bus_req.addr == ADDR_CTL1 && bus_req.wdata[TRIG_BIT]; // RULE_17 RULE_25
    assign mode_trig   = UNIT_ZERO && control_reg_zero[CE_BIT] && control_reg_one[2:0] == MODE_TRIG;
    assign mode_ones   = UNIT_ZERO && control_reg_zero[CE_BIT] && control_reg_one[2:0] == MODE_ONES; // RULE_09
    assign active_mode = mode_trig || mode_ones;

    // Event input synchroniser, change valid while stages 2 and 3 differ
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ev_sync <= 3'h0;
        else if (clk_en)
            ev_sync <= {ev_sync[1:0], event_in};
    end

    // Valid edge selection
    always_comb
    begin
        case (edge_select_reg[EDGE_LSB +: 2]) // RULE_20
            EDGE_RISE: ev_edge = ev_sync[1] && !ev_sync[2];
            EDGE_FALL: ev_edge = !ev_sync[1] && ev_sync[2];
            EDGE_BOTH: ev_edge = ev_sync[1] != ev_sync[2];
            default:   ev_edge = 1'b0;
        endcase
    end

    assign tick       = run && (control_reg_one[EVSEL_BIT] ? ev_edge : count_tick);
    assign take_trig  = sw_trig && active_mode && (mode_trig || !run); // RULE_10 RULE_14
    assign period_hit = tick && cnt == buf_q[0];
    assign clear_evt  = take_trig || period_hit;

    // ==========================================================
    // Counter next state
    always_comb
    begin
        next_cnt = cnt;
        next_run = run;
        if (!active_mode)
        begin
            next_cnt = CNT_MAX;
            next_run = 1'b0;
        end
        else if (take_trig)
        begin
            next_cnt = CNT_ZERO; // RULE_04 RULE_05 RULE_06 RULE_07 RULE_12
            next_run = 1'b1;
        end
        else if (period_hit)
        begin
            next_cnt = CNT_ZERO; // RULE_02 RULE_13
            next_run = mode_trig;
        end
        else if (tick)
        begin
            next_cnt = cnt + CNT_ONE;
        end
    end

    // Channel activity and interrupt decode
    always_comb
    begin
        next_act[0] = next_run && active_mode; // RULE_11
        for (int b = 1; b < 4; b++)
        begin
            next_act[b] = next_run && chan_active(mode_ones, next_cnt, buf_q[b], buf_q[0]);
            next_ch_irq[b-1] = tick && !take_trig && next_cnt == buf_q[b]; // RULE_08 RULE_16 RULE_05
        end
    end

    // Counter and run state
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= CNT_MAX;
            run <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt <= next_cnt;
            run <= next_run;
        end
    end

    // ==========================================================
    // Buffer reload on counter clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reload_pending <= 1'b0;
            for (int i = 0; i < 4; i++)
                buf_q[i] <= RST_CCR;
        end
        else if (clk_en)
        begin
            if (!run && !take_trig)
            begin
                for (int i = 0; i < 4; i++)
                    buf_q[i] <= ccr[i];
                reload_pending <= 1'b0;
            end
            else if (clear_evt && reload_pending)
            begin
                for (int i = 0; i < 4; i++)
                    buf_q[i] <= ccr[i]; // RULE_23
                reload_pending <= 1'b0;
            end
            if (wr_hit && bus_req.addr == ADDR_CMP1)
                reload_pending <= 1'b1; // RULE_23
        end
    end

    // ==========================================================
    // Interrupt pulses and pins
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            period_match_irq   <= 1'b0;
            channel_match_irq  <= 3'h0;
            act                <= 4'h0;
            period_output_pin  <= 1'b0;
            channel_output_pin <= 3'h0;
        end
        else if (clk_en)
        begin
            period_match_irq  <= period_hit && !take_trig && active_mode; // RULE_02 RULE_07 RULE_16
            channel_match_irq <= active_mode ? next_ch_irq : 3'h0;
            act               <= next_act;
            // Enable gates, level bit is the waiting level
            period_output_pin <= output_control_reg[0] && (output_control_reg[1] ^ next_act[0]); // RULE_19
            for (int b = 1; b < 4; b++)
                channel_output_pin[b-1] <= output_control_reg[2*b] && (output_control_reg[2*b+1] ^ next_act[b]);
        end
    end

    // ==========================================================
    // Register reads, data in the following cycle only
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= RST_CCR;
        else if (clk_en)
        begin
            rdata <= 16'h0000;
            if (bus_req.rd)
            begin
                case (bus_req.addr)
                    ADDR_CTL0: rdata <= {8'h00, control_reg_zero};
                    ADDR_CTL1: rdata <= {8'h00, control_reg_one};
                    ADDR_OUTC: rdata <= {8'h00, output_control_reg};
                    ADDR_INC:  rdata <= {8'h00, input_control_reg};
                    ADDR_EDGE: rdata <= {8'h00, edge_select_reg};
                    ADDR_OPT:  rdata <= {8'h00, option_reg};
                    ADDR_CNT:  rdata <= cnt; // RULE_21
                    ADDR_PER:  rdata <= ccr[0];
                    ADDR_CMP1: rdata <= ccr[1];
                    ADDR_CMP2: rdata <= ccr[2];
                    ADDR_CMP3: rdata <= ccr[3];
                    default:   rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Checks
    a_zero_duty_out: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
        (clk_en && mode_trig && !clear_evt && buf_q[1] == CNT_ZERO) |=> !act[1])
        else $error("zero compare drove channel 1 active");

    a_period_clear_irq: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
        (clk_en && mode_trig && period_hit && !take_trig) |=> (cnt == CNT_ZERO && period_match_irq))
        else $error("period match did not clear and interrupt");

    a_full_duty_out: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
        (clk_en && mode_trig && next_run && buf_q[2] == buf_q[0] + CNT_ONE && buf_q[0] != CNT_MAX) |=> act[2])
        else $error("full duty compare lost active level");

    a_trig_restart_cnt: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
        (clk_en && mode_trig && sw_trig) |=> (cnt == CNT_ZERO && run && !period_match_irq))
        else $error("trigger did not restart counter");

    a_trig_mask_ch: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
        (clk_en && take_trig) |=> channel_match_irq == 3'h0)
        else $error("channel interrupt not suppressed by trigger");

    a_ones_ignore_trig: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
        (clk_en && mode_ones && run && sw_trig && tick && !period_hit) |=> cnt == $past(cnt) + CNT_ONE)
        else $error("trigger disturbed running one-shot");

    a_ones_stop_end: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
        (clk_en && mode_ones && period_hit && !take_trig) |=> (!run && cnt == CNT_ZERO) [*1] ##1 (!clk_en || run || cnt == CNT_ZERO))
        else $error("one-shot did not stop at zero");

    a_ones_ch0_level: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
        (clk_en && mode_ones && output_control_reg[1:0] == 2'b01) |=> period_output_pin == run)
        else $error("channel 0 level does not follow counting");

    a_count_readback: assert property (@(posedge clock) disable iff (!rst_n) // RULE_21
        (clk_en && bus_req.rd && bus_req.addr == ADDR_CNT) |=> rdata == $past(cnt))
        else $error("counter readback mismatch");

    a_reload_on_clear: assert property (@(posedge clock) disable iff (!rst_n) // RULE_23
        (clk_en && run && clear_evt && reload_pending) |=> (buf_q[1] == $past(ccr[1]) && !reload_pending ||
        $past(wr_hit && bus_req.addr == ADDR_CMP1)))
        else $error("buffers not reloaded at clear");

    a_unit_only_zero: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
        !UNIT_ZERO |-> !run)
        else $error("pulse mode ran outside unit zero");

endmodule : tpt_timer

// *** verif/tpt_load.sv ***
`timescale 1ns/10ps
// ====================
// External loads on the four timer pins
module tpt_load (
    input  wire logic        clock,
    input  wire logic        clear,
    input  wire logic [3:0]  pins,
    output logic      [15:0] hi [4]
);
    // Active-high cycle tally per load, restarted by clear
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (clear)
                hi[i] <= 16'h0000;
            else
                hi[i] <= hi[i] + {15'h0000, pins[i]};
        end
    end
endmodule : tpt_load

// *** verif/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import tpt_pkg::*;
    logic         clock;
    logic         rst_n;
    logic         clk_en;
    logic         count_tick;
    logic         event_in;
    logic         clr;
    tpt_bus_req_s req;
    logic [15:0]  rdata;
    logic [15:0]  v;
    logic         pm;
    logic         po;
    logic         po_b;
    logic [2:0]   cm;
    logic [2:0]   co;
    logic [2:0]   co_b;
    logic [15:0]  hi [4];
    logic [15:0]  pm_n;
    logic [15:0]  cm_n [3];
    int           fail_count;
    int           check_count;

    // ====================
    // Units under test and loads
    tpt_timer i_tpt_timer (.clock, .rst_n, .clk_en, .count_tick, .event_in, .bus_req(req),
        .rdata, .period_match_irq(pm), .channel_match_irq(cm), .period_output_pin(po),
        .channel_output_pin(co));
    tpt_timer #(.UNIT_ZERO(1'b0)) i_tpt_timer_b (.clock, .rst_n, .clk_en, .count_tick,
        .event_in, .bus_req(req), .rdata(), .period_match_irq(), .channel_match_irq(),
        .period_output_pin(po_b), .channel_output_pin(co_b));
    tpt_load i_tpt_load (.clock, .clear(clr), .pins({co, po}), .hi);

    // Clock at 100 MHz
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Interrupt pulse tallies
    always @(posedge clock)
    begin
        if (clr)
        begin
            pm_n <= 16'h0000;
            cm_n <= '{3{16'h0000}};
        end
        else
        begin
            pm_n <= pm_n + {15'h0000, pm};
            for (int i = 0; i < 3; i++)
                cm_n[i] <= cm_n[i] + {15'h0000, cm[i]};
        end
    end

    // ====================
    // Bus and compare helpers
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic clear_loads();
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
    endtask : clear_loads

    // ====================
    // One-shot pulse, retrigger, waiting levels
    task automatic t_one_shot();
        wr(ADDR_INC, 16'hFFFF);
        wr(ADDR_OPT, 16'hFFFF);
        wr(ADDR_PER, 16'h0003);
        wr(ADDR_CMP2, 16'h0005);
        wr(ADDR_CMP3, 16'h0000);
        wr(ADDR_CMP1, 16'h0001);
        wr(ADDR_OUTC, 16'h00FE);
        wr(ADDR_CTL1, 16'h0003);
        wr(ADDR_CTL0, 16'h0080);
        repeat (3) @(posedge clock);
        #1;
        chk("waiting pins", 16'h000E, {12'h000, co, po});
        wr(ADDR_OUTC, 16'h0055);
        clear_loads();
        wr(ADDR_CTL1, 16'h0043);
        wr(ADDR_CTL1, 16'h0043);
        #1;
        chk("ch0 running", 16'h0001, {15'h0000, po});
        chk("unit b pins", 16'h0000, {12'h000, co_b, po_b});
        repeat (10) @(posedge clock);
        #1;
        chk("ch0 active", 16'h0004, hi[0]);
        chk("ch1 width", 16'h0003, hi[1]);
        chk("ch2 width", 16'h0000, hi[2]);
        chk("ch3 width", 16'h0004, hi[3]);
        chk("period irqs", 16'h0001, pm_n);
        chk("ch1 irqs", 16'h0001, cm_n[0]);
        chk("ch2 irqs", 16'h0000, cm_n[1]);
        rd(ADDR_CNT, v);
        chk("count after pulse", CNT_ZERO, v);
        rd(ADDR_CTL1, v);
        chk("control one", 16'h0003, v);
        rd(4'h7, v);
        chk("unmapped", 16'h0000, v);
        clear_loads();
        wr(ADDR_CTL1, 16'h0043);
        repeat (10) @(posedge clock);
        #1;
        chk("second ch1 width", 16'h0003, hi[1]);
        $display("one-shot test done");
    endtask : t_one_shot

    // ====================
    // Triggered PWM duty, interrupts, retrigger
    task automatic t_pwm();
        wr(ADDR_CTL0, 16'h0000);
        wr(ADDR_CTL1, {13'h0000, MODE_TRIG});
        wr(ADDR_PER, 16'h0004);
        wr(ADDR_CMP2, 16'h0005);
        wr(ADDR_CMP3, 16'h0002);
        wr(ADDR_CMP1, 16'h0000);
        wr(ADDR_CTL0, 16'h0080);
        wr(ADDR_CTL1, {9'h000, 1'b1, 3'h0, MODE_TRIG});
        repeat (8) @(posedge clock);
        clear_loads();
        repeat (20) @(posedge clock);
        #1;
        chk("pwm ch1 zero duty", 16'h0000, hi[1]);
        chk("pwm ch2 full duty", 16'h0014, hi[2]);
        chk("pwm ch3 width", 16'h0008, hi[3]);
        chk("pwm period irqs", 16'h0004, pm_n);
        chk("pwm ch1 irqs", 16'h0004, cm_n[0]);
        chk("pwm ch3 irqs", 16'h0004, cm_n[2]);
        wr(ADDR_CTL1, {9'h000, 1'b1, 3'h0, MODE_TRIG});
        rd(ADDR_CNT, v);
        chk("retrigger count", CNT_ONE, v);
        // Low clock enable holds the counter
        @(posedge clock);
        clk_en <= 1'b0;
        repeat (6) @(posedge clock);
        clk_en <= 1'b1;
        rd(ADDR_CNT, v);
        chk("frozen count", 16'h0004, v);
        // Compare change waits for a channel 1 write
        wr(ADDR_CMP3, 16'h0003);
        repeat (8) @(posedge clock);
        clear_loads();
        repeat (20) @(posedge clock);
        #1;
        chk("ch3 before reload", 16'h0008, hi[3]);
        wr(ADDR_CMP1, 16'h0000);
        repeat (8) @(posedge clock);
        clear_loads();
        repeat (20) @(posedge clock);
        #1;
        chk("ch3 after reload", 16'h000C, hi[3]);
        $display("pwm test done");
    endtask : t_pwm

    // ====================
    // Event input edges as count source
    task automatic t_event();
        logic [1:0]  edges [3] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
        logic [15:0] want [3] = '{16'h0003, 16'h0003, 16'h0006};
        @(posedge clock);
        count_tick <= 1'b0;
        wr(ADDR_CTL0, 16'h0000);
        wr(ADDR_PER, 16'hFFF0);
        wr(ADDR_CMP1, 16'hFFF0);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_CTL0, 16'h0000);
            wr(ADDR_EDGE, {12'h000, edges[i], 2'h0});
            wr(ADDR_CTL1, 16'h0023);
            wr(ADDR_CTL0, 16'h0080);
            rd(ADDR_CNT, v);
            chk("waiting count", CNT_MAX, v);
            wr(ADDR_CTL1, 16'h0063);
            rd(ADDR_CNT, v);
            chk("start count", CNT_ZERO, v);
            repeat (3)
            begin
                @(posedge clock);
                event_in <= 1'b1;
                repeat (4) @(posedge clock);
                event_in <= 1'b0;
                repeat (4) @(posedge clock);
            end
            rd(ADDR_CNT, v);
            chk("event count", want[i], v);
        end
        $display("event test done");
    endtask : t_event

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // ====================
    // Main sequence and watchdog
    initial
    begin
        fail_count = 0;
        check_count = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        count_tick = 1'b1;
        event_in = 1'b0;
        clr = 1'b0;
        req = '{addr: 4'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_one_shot();
        t_pwm();
        t_event();
        end_of_test();
    end

    initial
    begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule : testbench
